// file: core/irir_regs.svh
// Register offsets, field positions, reset values and counts of the identity and record-info bank
`ifndef IRIR_REGS_SVH
`define IRIR_REGS_SVH

// ----------------------------------------------------------------
// Register byte addresses (7-bit port address, even byte = low half)
// ----------------------------------------------------------------
`define IRIR_ADDR_TIME_LO 7'h4c
`define IRIR_ADDR_TIME_HI 7'h4e
`define IRIR_ADDR_BUILD_DAY_AND_FIRMWARE_LEVEL 7'h52
`define IRIR_ADDR_BUILD_YEAR_AND_MONTH 7'h54
`define IRIR_ADDR_MODEL 7'h56
`define IRIR_ADDR_SERIAL 7'h58
`define IRIR_ADDR_USER_ID 7'h5a
`define IRIR_ADDR_WEAR 7'h5c
`define IRIR_ADDR_AUX 7'h64
`define IRIR_ADDR_INFO1 7'h66
`define IRIR_ADDR_INFO2 7'h68

// ----------------------------------------------------------------
// Auxiliary control fields
// ----------------------------------------------------------------
`define IRIR_AUX_SYNC_BIT 12
`define IRIR_AUX_STAT_LOAD_BIT 10
`define IRIR_AUX_STAT_SAVE_BIT 9
`define IRIR_AUX_STAT_CLEAR_BIT 8
`define IRIR_AUX_TEST_ON_BIT 3
`define IRIR_AUX_TEST_OFF_BIT 2
`define IRIR_AUX_WRITE_MASK 16'h170c

// ----------------------------------------------------------------
// Record-info fields
// ----------------------------------------------------------------
`define IRIR_INFO1_RATE_MSB 15
`define IRIR_INFO1_RATE_LSB 14
`define IRIR_INFO1_WIN_MSB 13
`define IRIR_INFO1_WIN_LSB 12
`define IRIR_INFO1_AVG_MSB 7
`define IRIR_INFO2_AVG_MSB 3

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define IRIR_TIME_RESET 16'h0000
`define IRIR_AUX_RESET 16'h0000
`define IRIR_INFO_RESET 16'h0000
`define IRIR_RECORD_LAST_SLOT 4'h9
`define IRIR_FRAME_LAST_BIT 4'hf

`endif

// file: core/irir_pkg.sv
// Types shared by the identity and record-info bank
package irir_pkg;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef logic [15:0] irir_word_t;
   typedef logic [6:0] irir_addr_t;

   // Window codes of the spectral record
   typedef enum logic [1:0] {
      IRIR_WIN_RECT,
      IRIR_WIN_HANNING,
      IRIR_WIN_FLAT_TOP,
      IRIR_WIN_NONE
   } irir_window_t;

endpackage

// file: core/irir_spi_if.sv
// Frame interface between the serial shifter and the register bank
`timescale 1ns/1ps
interface irir_spi_if;
   logic frame_valid;            // One-cycle pulse, a 16-bit frame arrived
   irir_pkg::irir_word_t frame_word; // Received frame
   irir_pkg::irir_word_t tx_word;    // Word to send in the next frame

   modport shifter (output frame_valid, output frame_word, input tx_word);
   modport bank (input frame_valid, input frame_word, output tx_word);
endinterface

// file: core/irir_spi_shifter.sv
// Serial shifter, clock polarity and phase one, 16-bit frames
`timescale 1ns/1ps
`include "irir_regs.svh"
module irir_spi_shifter (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // Serial pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // Frame side
   irir_spi_if.shifter frm
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic sclk_prev_reg; // Serial clock one cycle back
   logic cs_n_prev_reg; // Select one cycle back
   logic [3:0] bit_count_reg; // Bits received in this frame
   logic [15:0] in_shift_reg; // Receive shifter
   logic [15:0] out_shift_reg; // Transmit shifter
   logic cs_start;
   logic sclk_rise;
   logic sclk_fall;

   // Edge detection on the sampled pins
   assign cs_start = cs_n_prev_reg & ~spi_cs_n;
   assign sclk_rise = ~sclk_prev_reg & spi_sclk & ~spi_cs_n;
   assign sclk_fall = sclk_prev_reg & ~spi_sclk & ~spi_cs_n;

   // Pin history
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sclk_prev_reg <= 1'b1;
         cs_n_prev_reg <= 1'b1;
      end else if (ce) begin
         sclk_prev_reg <= spi_sclk;
         cs_n_prev_reg <= spi_cs_n;
      end
   end

   // Receive path, sampled on rising serial clock
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bit_count_reg <= 4'h0;
         in_shift_reg <= 16'h0000;
         frm.frame_valid <= 1'b0;
         frm.frame_word <= 16'h0000;
      end else if (ce) begin
         frm.frame_valid <= 1'b0;
         if (spi_cs_n) begin
            // Deselect abandons a partial frame
            bit_count_reg <= 4'h0;
         end else if (sclk_rise) begin
            in_shift_reg <= {in_shift_reg[14:0], spi_mosi};
            bit_count_reg <= bit_count_reg + 4'h1;
            if (bit_count_reg == `IRIR_FRAME_LAST_BIT) begin
               frm.frame_valid <= 1'b1;
               frm.frame_word <= {in_shift_reg[14:0], spi_mosi};
            end
         end
      end
   end

   // Transmit path, loaded at select and shifted on falling serial clock
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         out_shift_reg <= 16'h0000;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else if (ce) begin
         spi_miso_oe <= ~spi_cs_n;
         if (cs_start) begin
            out_shift_reg <= frm.tx_word;
            spi_miso <= frm.tx_word[15];
         end else if (sclk_fall) begin
            // Each falling edge launches the bit that the next rising edge samples
            out_shift_reg <= {out_shift_reg[14:0], 1'b0};
            spi_miso <= out_shift_reg[15];
         end
      end
   end

endmodule // irir_spi_shifter

// file: core/irir_top.sv
// Identity, timestamp, auxiliary control and record-info register bank
`timescale 1ns/1ps
`include "irir_regs.svh"

module irir_top #(
   // Model number code; the value is arbitrary
   parameter logic [15:0] MODEL_CODE = 16'h1234
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // Serial register port
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // Capture timestamp source
   input wire logic capture_event,
   input wire logic [31:0] capture_seconds,
   // Factory programmed words
   input wire logic [15:0] factory_build_day_and_firmware_level,
   input wire logic [15:0] factory_build_year_and_month,
   input wire logic [15:0] factory_serial,
   // Nonvolatile store
   input wire logic [15:0] nv_user_id,
   input wire logic [15:0] nv_wear_count,
   output logic user_id_save,
   output logic [15:0] user_id_word,
   output logic [15:0] wear_count_word,
   // Record store events
   input wire logic records_cleared,
   input wire logic record_slot_filled,
   input wire logic [3:0] record_slot_index,
   // Spectral record results
   input wire logic spectral_done,
   input wire logic spectral_mode,
   input wire logic [1:0] spectral_rate,
   input wire logic [1:0] spectral_window,
   input wire logic [7:0] spectral_averages,
   input wire logic [3:0] spectral_avg_setting,
   // External sync and capture start
   input wire logic sync_pin,
   output logic capture_start,
   output logic sync_capture_enable,
   // Statistics commands and their completions
   output logic stat_load_req,
   output logic stat_save_req,
   output logic stat_clear_req,
   input wire logic stat_load_done,
   input wire logic stat_save_done,
   input wire logic stat_clear_done,
   // Self-test control
   output logic self_test_active
);

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   irir_spi_if frm_if (); // Frame link to the shifter

   irir_pkg::irir_word_t time_lo_reg; // Timestamp low word
   irir_pkg::irir_word_t time_hi_reg; // Timestamp high word
   irir_pkg::irir_word_t user_id_reg; // User identifier
   irir_pkg::irir_word_t wear_reg; // Record store wear counter
   irir_pkg::irir_word_t aux_reg; // Auxiliary control word
   irir_pkg::irir_word_t info1_reg; // Spectral record settings
   irir_pkg::irir_word_t info2_reg; // Spectral record averaging
   irir_pkg::irir_word_t tx_reg; // Read answer for the next frame
   logic restore_pending_reg; // Nonvolatile values not yet loaded
   logic sync_prev_reg; // Sync pin one cycle back

   logic wr_frame; // Write frame arrived
   logic rd_frame; // Read frame arrived
   irir_pkg::irir_addr_t frame_addr; // Byte address of the frame
   logic [7:0] frame_data; // Byte written by the frame
   logic wr_aux_lo; // Write to aux control low byte
   logic wr_aux_hi; // Write to aux control high byte
   logic wr_user_lo; // Write to user identifier low byte
   logic wr_user_hi; // Write to user identifier high byte
   irir_pkg::irir_word_t aux_written; // Aux word after the byte write
   logic store_full_event; // Tenth record location filled

   // ----------------------------------------------------------------
   // Serial shifter
   // ----------------------------------------------------------------
   irir_spi_shifter u_shifter (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe),
      .frm(frm_if.shifter)
   );

   assign frm_if.tx_word = tx_reg;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // Merge one byte into a word; odd address writes the high half
   function automatic irir_pkg::irir_word_t merge_byte(input irir_pkg::irir_word_t old_word,
                                                       input logic high_half,
                                                       input logic [7:0] data);
      irir_pkg::irir_word_t res;
      res = old_word;
      if (high_half) begin
         res[15:8] = data;
      end else begin
         res[7:0] = data;
      end
      return res;
   endfunction

   // Word address of a byte address, odd byte mapped onto its even word
   function automatic irir_pkg::irir_addr_t word_addr(input irir_pkg::irir_addr_t a);
      return {a[6:1], 1'b0};
   endfunction

   // ----------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------

   // Bit 15 marks a write, bits 14..8 the address, bits 7..0 the data
   assign wr_frame = frm_if.frame_valid & frm_if.frame_word[15];
   assign rd_frame = frm_if.frame_valid & ~frm_if.frame_word[15];
   assign frame_addr = frm_if.frame_word[14:8];
   assign frame_data = frm_if.frame_word[7:0];

   // Only the two writable words decode; every other write falls away
   assign wr_aux_lo = wr_frame && (frame_addr == `IRIR_ADDR_AUX);
   assign wr_aux_hi = wr_frame && (frame_addr == (`IRIR_ADDR_AUX | 7'h01));
   assign wr_user_lo = wr_frame && (frame_addr == `IRIR_ADDR_USER_ID);
   assign wr_user_hi = wr_frame && (frame_addr == (`IRIR_ADDR_USER_ID | 7'h01));

   // Unused control bits are masked so they read back zero
   assign aux_written = merge_byte(aux_reg, wr_aux_hi, frame_data)
                        & `IRIR_AUX_WRITE_MASK;

   // The tenth location is index nine
   assign store_full_event = record_slot_filled &&
                             (record_slot_index == `IRIR_RECORD_LAST_SLOT);

   // ----------------------------------------------------------------
   // Read answer, sent in the frame after the read command
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_reg <= 16'h0000;
      end else if (ce && rd_frame) begin
         unique case (word_addr(frame_addr))
            `IRIR_ADDR_TIME_LO: tx_reg <= time_lo_reg;
            `IRIR_ADDR_TIME_HI: tx_reg <= time_hi_reg;
            `IRIR_ADDR_BUILD_DAY_AND_FIRMWARE_LEVEL: tx_reg <= factory_build_day_and_firmware_level;
            `IRIR_ADDR_BUILD_YEAR_AND_MONTH: tx_reg <= factory_build_year_and_month;
            `IRIR_ADDR_MODEL: tx_reg <= MODEL_CODE;
            `IRIR_ADDR_SERIAL: tx_reg <= factory_serial;
            `IRIR_ADDR_USER_ID: tx_reg <= user_id_reg;
            `IRIR_ADDR_WEAR: tx_reg <= wear_reg;
            `IRIR_ADDR_AUX: tx_reg <= aux_reg;
            `IRIR_ADDR_INFO1: tx_reg <= info1_reg;
            `IRIR_ADDR_INFO2: tx_reg <= info2_reg;
            // Addresses outside this bank answer zero
            default: tx_reg <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Capture timestamp
   // ----------------------------------------------------------------

   // Latch both words in the same cycle; reads are not shadowed, so a capture between the two reads mixes them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         time_lo_reg <= `IRIR_TIME_RESET;
         time_hi_reg <= `IRIR_TIME_RESET;
      end else if (ce && capture_event) begin
         time_lo_reg <= capture_seconds[15:0];
         time_hi_reg <= capture_seconds[31:16];
      end
   end

   // ----------------------------------------------------------------
   // Nonvolatile restore
   // ----------------------------------------------------------------

   // Stored values are picked up in the first enabled cycle after reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         restore_pending_reg <= 1'b1;
      end else if (ce) begin
         restore_pending_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // User identifier
   // ----------------------------------------------------------------

   // Restored after reset; a host byte write updates it and asks for a save
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         user_id_reg <= 16'h0000;
         user_id_save <= 1'b0;
      end else if (ce) begin
         user_id_save <= wr_user_lo | wr_user_hi;
         if (restore_pending_reg) begin
            user_id_reg <= nv_user_id;
         end else if (wr_user_lo || wr_user_hi) begin
            user_id_reg <= merge_byte(user_id_reg, wr_user_hi, frame_data);
         end
      end
   end

   // Value handed to the nonvolatile store
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         user_id_word <= 16'h0000;
      end else if (ce) begin
         user_id_word <= user_id_reg;
      end
   end

   // ----------------------------------------------------------------
   // Record store wear counter
   // ----------------------------------------------------------------

   // A clear and a fill of the tenth location in one cycle both count; the counter wraps
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wear_reg <= 16'h0000;
      end else if (ce) begin
         if (restore_pending_reg) begin
            wear_reg <= nv_wear_count;
         end else begin
            wear_reg <= wear_reg + {15'h0000, records_cleared}
                        + {15'h0000, store_full_event};
         end
      end
   end

   // Counter mirrored out for the nonvolatile store
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wear_count_word <= 16'h0000;
      end else if (ce) begin
         wear_count_word <= wear_reg;
      end
   end

   // ----------------------------------------------------------------
   // Auxiliary control word
   // ----------------------------------------------------------------

   // Statistics bits stay up until their action reports done; a host
   // write in the done cycle wins. Self-test bits clear the next cycle.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aux_reg <= `IRIR_AUX_RESET;
      end else if (ce) begin
         if (wr_aux_lo || wr_aux_hi) begin
            aux_reg <= aux_written;
         end else begin
            // Self-test commands act at once
            aux_reg[`IRIR_AUX_TEST_ON_BIT] <= 1'b0;
            aux_reg[`IRIR_AUX_TEST_OFF_BIT] <= 1'b0;
            // Statistics commands clear on completion
            if (stat_load_done) begin
               aux_reg[`IRIR_AUX_STAT_LOAD_BIT] <= 1'b0;
            end
            if (stat_save_done) begin
               aux_reg[`IRIR_AUX_STAT_SAVE_BIT] <= 1'b0;
            end
            if (stat_clear_done) begin
               aux_reg[`IRIR_AUX_STAT_CLEAR_BIT] <= 1'b0;
            end
         end
      end
   end

   // Statistics request outputs follow the command bits
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stat_load_req <= 1'b0;
         stat_save_req <= 1'b0;
         stat_clear_req <= 1'b0;
      end else if (ce) begin
         // Host must set the record pointer before loading
         stat_load_req <= aux_reg[`IRIR_AUX_STAT_LOAD_BIT] & ~stat_load_done;
         stat_save_req <= aux_reg[`IRIR_AUX_STAT_SAVE_BIT] & ~stat_save_done;
         stat_clear_req <= aux_reg[`IRIR_AUX_STAT_CLEAR_BIT] & ~stat_clear_done;
      end
   end

   // ----------------------------------------------------------------
   // Self-test
   // ----------------------------------------------------------------

   // Clear takes priority when both bits are written together
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         self_test_active <= 1'b0;
      end else if (ce) begin
         if (aux_reg[`IRIR_AUX_TEST_OFF_BIT]) begin
            self_test_active <= 1'b0;
         end else if (aux_reg[`IRIR_AUX_TEST_ON_BIT]) begin
            self_test_active <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // External sync
   // ----------------------------------------------------------------

   // Rising sync edge starts a capture only while sensitivity is on
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync_prev_reg <= 1'b0;
         capture_start <= 1'b0;
         sync_capture_enable <= 1'b0;
      end else if (ce) begin
         sync_prev_reg <= sync_pin;
         sync_capture_enable <= aux_reg[`IRIR_AUX_SYNC_BIT];
         capture_start <= aux_reg[`IRIR_AUX_SYNC_BIT] & sync_pin & ~sync_prev_reg;
      end
   end

   // ----------------------------------------------------------------
   // Spectral record information
   // ----------------------------------------------------------------

   // Updated only for results of the spectral capture modes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         info1_reg <= `IRIR_INFO_RESET;
         info2_reg <= `IRIR_INFO_RESET;
      end else if (ce && spectral_done && spectral_mode) begin
         info1_reg <= 16'h0000;
         info1_reg[`IRIR_INFO1_RATE_MSB:`IRIR_INFO1_RATE_LSB] <= spectral_rate;
         info1_reg[`IRIR_INFO1_WIN_MSB:`IRIR_INFO1_WIN_LSB] <= spectral_window;
         // Only the low eight bits of the average count fit
         info1_reg[`IRIR_INFO1_AVG_MSB:0] <= spectral_averages;
         info2_reg <= {12'h000, spectral_avg_setting[`IRIR_INFO2_AVG_MSB:0]};
      end
   end

endmodule // irir_top

// file: sim/irir_top_assertions.sv
// Port checker of the identity and record-info bank
`timescale 1ns/1ps
module irir_top_assertions (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Watched ports
   input wire logic spi_cs_n,
   input wire logic spi_miso_oe,
   input wire logic user_id_save,
   input wire logic [15:0] wear_count_word,
   input wire logic capture_start,
   input wire logic sync_capture_enable,
   input wire logic stat_load_req,
   input wire logic stat_save_req,
   input wire logic stat_clear_req,
   input wire logic stat_load_done,
   input wire logic stat_save_done,
   input wire logic stat_clear_done
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [1:0] up_cnt; // Cycles since reset, saturating at three
   // ----------------
   // Settle counter
   // ----------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         up_cnt <= 2'h0;
      end else if (up_cnt != 2'h3) begin
         up_cnt <= up_cnt + 2'h1;
      end
   end
   a_start_gated: assert property (capture_start |-> sync_capture_enable)
      else $error("capture start while sync is disabled");
   a_start_single: assert property (capture_start |=> !capture_start)
      else $error("capture start longer than one cycle");
   a_load_drop: assert property (stat_load_done |-> ##[1:2] !stat_load_req)
      else $error("load request kept after done");
   a_save_drop: assert property (stat_save_done |-> ##[1:2] !stat_save_req)
      else $error("save request kept after done");
   a_clear_drop: assert property (stat_clear_done |-> ##[1:2] !stat_clear_req)
      else $error("clear request kept after done");
   a_id_save_once: assert property (user_id_save |=> !user_id_save)
      else $error("user id save longer than one cycle");
   a_wear_step: assert property (up_cnt == 2'h3 |->
      16'(wear_count_word - $past(wear_count_word)) <= 16'h0002)
      else $error("wear counter moved by more than two");
   a_oe_select: assert property (1'b1 |=> spi_miso_oe == !$past(spi_cs_n))
      else $error("serial output enable does not follow select");
endmodule // irir_top_assertions

bind irir_top irir_top_assertions chk_i (.sys_clk, .rst, .spi_cs_n, .spi_miso_oe,
   .user_id_save, .wear_count_word, .capture_start, .sync_capture_enable, .stat_load_req,
   .stat_save_req, .stat_clear_req, .stat_load_done, .stat_save_done, .stat_clear_done);

// file: sim/irir_host_model.sv
// Serial host model sending 16-bit mode-3 frames
`timescale 1ns/1ps
module irir_host_model (
   // Clock
   input wire logic sys_clk,
   // Serial pins
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // One frame, MSB first; hp is the half period in cycles, three or more
   task automatic xfer(input logic [15:0] w, input int hp, output logic [15:0] q);
      @(posedge sys_clk) spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (hp) @(posedge sys_clk);
         spi_sclk <= 1'b0;
         spi_mosi <= w[i];
         repeat (hp) @(posedge sys_clk);
         spi_sclk <= 1'b1;
         q[i] = spi_miso;
      end
      repeat (hp) @(posedge sys_clk);
      spi_cs_n <= 1'b1;
      // Idle data line shows the inverse of the last bit
      spi_mosi <= ~spi_mosi;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule // irir_host_model

// file: sim/tb_top.sv
// Self-checking bench of the identity and record-info bank
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] ev = 8'h00; // Event and completion pulses
   logic sync_pin = 1'b0, ce = 1'b1;
   logic mode = 1'b0;
   logic [1:0] rate = 2'h0, win = 2'h0;
   logic [7:0] avg = 8'h00;
   logic [3:0] aset = 4'h0, slot = 4'h0;
   logic [31:0] secs = 32'h0, seed = 32'h00015270;
   logic [15:0] day, ym, ser, nv_id, r, v, e1, e2;
   logic [15:0] nv_wear = 16'hffff; // Wraps on the first count
   logic [6:0] ro [5] = '{7'h4d, 7'h53, 7'h56, 7'h59, 7'h67};
   wire sclk, cs_n, mosi, miso, oe, start, sen, ld, sv, cl, st, save;
   wire [15:0] id_w, wear_w;
   int error_cnt = 0, check_count = 0, n;
   always #2 sys_clk = ~sys_clk;
   irir_top #(.MODEL_CODE(16'h5a3c)) dut (.sys_clk, .rst, .ce, .spi_sclk(sclk),
      .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe),
      .capture_event(ev[0]), .capture_seconds(secs), .factory_build_day_and_firmware_level(day),
      .factory_build_year_and_month(ym), .factory_serial(ser), .nv_user_id(nv_id), .nv_wear_count(nv_wear),
      .user_id_save(save), .user_id_word(id_w), .wear_count_word(wear_w),
      .records_cleared(ev[1]), .record_slot_filled(ev[2]), .record_slot_index(slot),
      .spectral_done(ev[3]), .spectral_mode(mode), .spectral_rate(rate), .spectral_window(win),
      .spectral_averages(avg), .spectral_avg_setting(aset), .sync_pin, .capture_start(start),
      .sync_capture_enable(sen), .stat_load_req(ld), .stat_save_req(sv), .stat_clear_req(cl),
      .stat_load_done(ev[4]), .stat_save_done(ev[5]), .stat_clear_done(ev[6]),
      .self_test_active(st));
   irir_host_model host (.sys_clk, .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   // Read answer comes in the following frame
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      host.xfer({1'b0, a, 8'h00}, 4, r);
      host.xfer(16'h0000, 3, r);
      chk(r, exp);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.xfer({1'b1, a, d}, 3, r);
   endtask
   task automatic pulse(input logic [7:0] m);
      @(posedge sys_clk) ev <= m;
      @(posedge sys_clk) ev <= 8'h00;
      repeat (4) @(posedge sys_clk);
   endtask
   // Counts capture starts over a short span after a sync rise
   task automatic sync_try(input logic [15:0] exp);
      n = 0;
      @(posedge sys_clk) sync_pin <= 1'b1;
      repeat (8) begin
         @(posedge sys_clk);
         #1 n += int'(start);
      end
      @(posedge sys_clk) sync_pin <= 1'b0;
      chk(16'(n), exp);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      error_cnt++;
      test_done();
   end
   initial begin
      {day, ym} = xs();
      {ser, nv_id} = xs();
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      // Second pass follows writes to read-only words
      for (int i = 0; i < 2; i++) begin
         if (i == 1) begin
            foreach (ro[j]) wr(ro[j], 8'hff);
         end
         rd(7'h4c, 16'h0000);
         rd(7'h4f, 16'h0000);
         rd(7'h52, day);
         rd(7'h54, ym);
         rd(7'h56, 16'h5a3c);
         rd(7'h58, ser);
         rd(7'h5a, nv_id);
         rd(7'h66, 16'h0000);
         rd(7'h69, 16'h0000);
         rd(7'h64, 16'h0000);
         rd(7'h70, 16'h0000);
      end
      $display("test identity done");
      v = xs();
      wr(7'h5a, v[7:0]);
      wr(7'h5b, v[15:8]);
      rd(7'h5a, v);
      chk(id_w, v);
      secs <= xs();
      pulse(8'h01);
      rd(7'h4c, secs[15:0]);
      rd(7'h4e, secs[31:16]);
      slot <= 4'h5;
      pulse(8'h04);
      slot <= 4'h9;
      pulse(8'h04);
      pulse(8'h02);
      pulse(8'h06);
      rd(7'h5c, nv_wear + 16'h0004);
      chk(wear_w, nv_wear + 16'h0004);
      // A clear seen while the clock enable is low must not count
      ce <= 1'b0;
      pulse(8'h02);
      ce <= 1'b1;
      rd(7'h5c, nv_wear + 16'h0004);
      $display("test counters done");
      wr(7'h65, 8'hff);
      rd(7'h64, 16'h1700);
      chk(16'({sen, ld, sv, cl}), 16'h000f);
      sync_try(16'h0001);
      pulse(8'h70);
      chk(16'({ld, sv, cl}), 16'h0000);
      wr(7'h64, 8'h08);
      chk(16'(st), 16'h0001);
      wr(7'h64, 8'h0c | v[7:0]);
      chk(16'(st), 16'h0000);
      rd(7'h64, 16'h1000);
      wr(7'h65, 8'h00);
      sync_try(16'h0000);
      $display("test control done");
      for (int i = 0; i < 5; i++) begin
         v = xs();
         @(posedge sys_clk);
         {rate, win, avg, aset, mode} <= {2'(i), 2'(i + 1), v[7:0], v[11:8], i < 4};
         if (i < 4) begin
            e1 = {2'(i), 2'(i + 1), 4'h0, v[7:0]};
            e2 = {12'h000, v[11:8]};
         end
         pulse(8'h08);
         rd(7'h66, e1);
         rd(7'h68, e2);
      end
      $display("test record info done");
      test_done();
   end
endmodule // tb_top
